// ==== inc/fpabs_pkg.sv ====
// Constants, register map and operation codes for the float ALU block.
// Assumes a 40-bit extended float: sign, 8-bit exponent, 31-bit fraction.
package fpabs_pkg;
    // Operand layout.
    localparam int          FW        = 40;
    localparam int          SGN       = 39;
    localparam logic [7:0]  EXP_INF   = 8'hFF;
    localparam logic [7:0]  EXP_TOP   = 8'hFE;
    localparam logic [39:0] ALL_ONES  = 40'hFF_FFFF_FFFF;
    localparam logic [39:0] POS_INF   = 40'h7F_8000_0000;
    localparam logic [39:0] LARGEST_NORMAL_VALUE  = 40'h7F_7FFF_FFFF;
    localparam logic [39:0] LOW8_MASK = 40'hFF_FFFF_FF00;
    // Register byte offsets.
    localparam logic [7:0]  FX_OFS    = 8'h00;
    localparam logic [7:0]  FY_OFS    = 8'h04;
    localparam logic [7:0]  EXT_OFS   = 8'h08;
    localparam logic [7:0]  MODE_OFS  = 8'h0C;
    localparam logic [7:0]  CMD_OFS   = 8'h10;
    localparam logic [7:0]  RES_OFS   = 8'h14;
    localparam logic [7:0]  STAT_OFS  = 8'h18;
    // Mode control fields and reset value.
    localparam int          MODE_TRUNC = 0;
    localparam int          MODE_R32   = 1;
    localparam logic [1:0]  MODE_RST   = 2'h0;
    // Status register fields.
    localparam int          F_Z       = 0;
    localparam int          F_U       = 1;
    localparam int          F_N       = 2;
    localparam int          F_V       = 3;
    localparam int          F_C       = 4;
    localparam int          F_S       = 5;
    localparam int          F_I       = 6;
    localparam int          HIST_LO   = 24;
    localparam int          HIST_HI   = 31;
    localparam logic [31:0] STAT_RST  = 32'h0000_0000;
    // Operation codes, written to the command register.
    typedef enum logic [2:0] {
        OP_ABS_ADD, OP_ABS_SUB, OP_AVG, OP_CMP, OP_NEG, OP_MAG, OP_PASS
    } fpabs_op_t;
    localparam logic [2:0]  OP_BAD    = 3'h7;
endpackage

// ==== inc/fpabs_alu_if.sv ====
// Carrier between the block's control logic and its add and round datapath.
// Assumes both ends share one clock; the path is purely combinational.
`timescale 1ns/1ps
`default_nettype none
interface fpabs_alu_if;
    logic [39:0] a;
    logic [39:0] b;
    logic        sub;
    logic        half;
    logic        trunc;
    logic        r32;
    logic [39:0] res;
    logic        ovf;
    logic        unf;
    logic        zr;
    modport core (output a, b, sub, half, trunc, r32, input res, ovf, unf, zr);
    modport alu  (input a, b, sub, half, trunc, r32, output res, ovf, unf, zr);
endinterface
`default_nettype wire

// ==== logic/fpabs_flush.sv ====
// Operand classifier: flushes denormals to a signed zero and tags specials.
// Assumes a 40-bit extended float on its input.
`timescale 1ns/1ps
`default_nettype none
module fpabs_flush import fpabs_pkg::*; (
    input  wire logic [39:0] raw,  // Operand as stored.
    output logic      [39:0] val,  // Operand with denormal flushed.
    output logic             nan,  // Not-a-number.
    output logic             inf,  // Infinity of either sign.
    output logic             zero  // Zero after flushing.
);
    // A zero exponent means zero or denormal; both become a signed zero.
    always_comb begin
        zero = (raw[38:31] == 8'h00);
        nan  = (raw[38:31] == EXP_INF) && (raw[30:0] != 31'h0);
        inf  = (raw[38:31] == EXP_INF) && (raw[30:0] == 31'h0);
        val  = zero ? {raw[SGN], 39'h0} : raw;
    end
endmodule
`default_nettype wire

// ==== logic/fpabs_addsub.sv ====
// Add, subtract and halve datapath with normalise and round.
// Assumes finite flushed operands; specials are overridden by the caller.
`timescale 1ns/1ps
`default_nettype none
module fpabs_addsub import fpabs_pkg::*; (
    fpabs_alu_if.alu bus  // Operands in, rounded result out.
);
    logic        bs;
    logic        eff_sub;
    logic        a_big;
    logic [39:0] big;
    logic [39:0] sml;
    logic [34:0] bm;
    logic [34:0] sm;
    logic [34:0] msk;
    logic [7:0]  dif;
    logic [35:0] sum;
    logic [35:0] nrm;
    logic [5:0]  lz;
    logic [9:0]  ex;
    logic [32:0] rnd;
    logic        g;
    logic        st;
    logic        lsb;

    // Align the smaller operand, keep three guard bits plus a sticky jam.
    always_comb begin
        bs      = bus.b[SGN] ^ bus.sub;
        eff_sub = bus.a[SGN] ^ bs;
        a_big   = bus.a[38:0] >= bus.b[38:0];
        big     = a_big ? bus.a : {bs, bus.b[38:0]};
        sml     = a_big ? {bs, bus.b[38:0]} : bus.a;
        bm      = {big[38:31] != 8'h00, big[30:0], 3'h0};
        dif     = big[38:31] - sml[38:31];
        msk     = (35'h1 << dif) - 35'h1;
        sm      = {sml[38:31] != 8'h00, sml[30:0], 3'h0};
        sm      = (sm >> dif) | {34'h0, |(sm & msk)};
        sum     = eff_sub ? {1'b0, bm} - {1'b0, sm} : {1'b0, bm} + {1'b0, sm};
        lz      = 6'h24;
        for (int i = 0; i < 36; i++) begin
            if (sum[i]) begin
                lz = 6'(35 - i);
            end
        end
        nrm = sum << lz;
        // Halving only decrements the exponent, before rounding.
        ex  = {2'h0, big[38:31]} + 10'h001 - {4'h0, lz} - {9'h0, bus.half};
        g   = bus.r32 ? nrm[11] : nrm[3];
        st  = bus.r32 ? |nrm[10:0] : |nrm[2:0];
        lsb = bus.r32 ? nrm[12] : nrm[4];
        rnd = {1'b0, nrm[35:12], bus.r32 ? 8'h00 : nrm[11:4]};
        if (!bus.trunc && g && (st || lsb)) begin
            rnd = rnd + (bus.r32 ? 33'h100 : 33'h1);
        end
        if (rnd[32]) begin
            rnd = rnd >> 1;
            ex  = ex + 10'h001;
        end
        bus.zr  = (sum == 36'h0);
        bus.ovf = !bus.zr && !ex[9] && (ex >= 10'h0FF);
        bus.unf = !bus.zr && (ex[9] || ex == 10'd0);
        bus.res = {big[SGN], ex[7:0], rnd[30:0]};
        if (bus.zr) begin
            bus.res = 40'h0;
        end
    end
endmodule
`default_nettype wire

// ==== logic/fpabs_top.sv ====
// Float ALU for absolute sum, absolute difference, average, compare,
// negate, magnitude and pass, with status flags and compare history.
// Assumes an APB master on ref_clk; operands are loaded before a command.
`timescale 1ns/1ps
`default_nettype none

module fpabs_top import fpabs_pkg::*; (
    input  wire logic        ref_clk,  // Core clock, 40 MHz.
    input  wire logic        nrst,     // Asynchronous reset, active low.
    input  wire logic [7:0]  paddr,    // APB byte address.
    input  wire logic        psel,     // APB select.
    input  wire logic        penable,  // APB access phase.
    input  wire logic        pwrite,   // APB direction, high for write.
    input  wire logic [31:0] pwdata,   // APB write data.
    input  wire logic [3:0]  pstrb,    // APB byte strobes.
    output logic      [31:0] prdata,   // APB read data.
    output logic             pready,   // APB ready.
    output logic             pslverr   // APB error on unmapped address.
);

    ////////////////////////////////////////////////////////////////////////
    // Storage.

    logic [31:0] first_float_source;
    logic [31:0] second_float_source;
    logic [15:0] ext_reg;
    logic [1:0]  mode_control_register;
    logic [39:0] float_destination;
    logic [31:0] arithmetic_status_register;

    logic        acc_wr;
    logic        go;
    fpabs_op_t   op;
    logic [39:0] x_f;
    logic [39:0] y_f;
    logic        x_nan;
    logic        y_nan;
    logic        x_inf;
    logic        y_inf;
    logic        x_zero;
    logic        y_zero;
    logic        trunc;
    logic        is_sub;
    logic        cmp_eq;
    logic        cmp_lt;
    logic [39:0] next_res;
    logic [6:0]  next_flags;

    fpabs_alu_if au ();

    ////////////////////////////////////////////////////////////////////////
    // Helper functions.

    // Merges write data into a register under the byte strobes.
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  stb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (stb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // True when an address is a register of this block.
    function automatic logic mapped(input logic [7:0] a);
        return (a == FX_OFS) || (a == FY_OFS) || (a == EXT_OFS) ||
               (a == MODE_OFS) || (a == CMD_OFS) || (a == RES_OFS) ||
               (a == STAT_OFS);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Operand conditioning and the shared add datapath.

    // Flushing happens once here so every operation sees the same operand.
    fpabs_flush u_fx (
        .raw  ({first_float_source, ext_reg[7:0]}),
        .val  (x_f),
        .nan  (x_nan),
        .inf  (x_inf),
        .zero (x_zero)
    );
    fpabs_flush u_fy (
        .raw  ({second_float_source, ext_reg[15:8]}),
        .val  (y_f),
        .nan  (y_nan),
        .inf  (y_inf),
        .zero (y_zero)
    );

    fpabs_addsub u_add (
        .bus (au)
    );

    // Writes and the command strobe act only at the access edge.
    assign acc_wr = psel && penable && pready && pwrite;
    assign go     = acc_wr && (paddr == CMD_OFS) && (pwdata[2:0] != OP_BAD);
    assign op     = fpabs_op_t'(pwdata[2:0]);
    assign trunc  = mode_control_register[MODE_TRUNC];
    assign is_sub = (op == OP_ABS_SUB);

    // Datapath control follows the requested operation and the mode bits.
    assign au.a     = x_f;
    assign au.b     = y_f;
    assign au.sub   = is_sub;
    assign au.half  = (op == OP_AVG);
    assign au.trunc = trunc;
    assign au.r32   = mode_control_register[MODE_R32];

    // Float compare on flushed operands; both zeros compare equal.
    always_comb begin
        cmp_eq = (x_f == y_f) || (x_zero && y_zero);
        if (cmp_eq) begin
            cmp_lt = 1'b0;
        end else if (x_f[SGN] != y_f[SGN]) begin
            cmp_lt = x_f[SGN];
        end else if (!x_f[SGN]) begin
            cmp_lt = x_f[38:0] < y_f[38:0];
        end else begin
            cmp_lt = x_f[38:0] > y_f[38:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result and flag selection.

    // All seven flags default to zero before the case so none is left stale.
    always_comb begin
        next_res   = 40'h0;
        next_flags = 7'h0;
        case (op)
            OP_ABS_ADD, OP_ABS_SUB, OP_AVG: begin
                if (x_nan || y_nan || (x_inf && y_inf &&
                        (x_f[SGN] ^ y_f[SGN] ^ is_sub))) begin
                    next_res        = ALL_ONES;
                    next_flags[F_I] = 1'b1;
                end else if (x_inf || y_inf) begin
                    next_res = {x_inf ? x_f[SGN] : y_f[SGN] ^ is_sub,
                                POS_INF[38:0]};
                end else if (au.ovf) begin
                    // Truncation saturates; nearest overflows to infinity.
                    next_res        = trunc ? LARGEST_NORMAL_VALUE : POS_INF;
                    next_res[SGN]   = au.res[SGN];
                    next_flags[F_V] = 1'b1;
                end else if (au.unf || au.zr) begin
                    next_res        = {au.res[SGN], 39'h0};
                    next_flags[F_Z] = 1'b1;
                    next_flags[F_U] = au.unf;
                end else begin
                    next_res = au.res;
                end
                if (op == OP_AVG) begin
                    next_flags[F_N] = next_res[SGN] && !next_flags[F_Z] &&
                                      !next_flags[F_I];
                end else if (!next_flags[F_I]) begin
                    next_res[SGN] = 1'b0;
                end
            end
            OP_CMP: begin
                next_flags[F_I] = x_nan || y_nan;
                next_flags[F_Z] = !next_flags[F_I] && cmp_eq;
                next_flags[F_N] = !next_flags[F_I] && cmp_lt;
                next_res        = float_destination;
            end
            OP_NEG: begin
                if (x_nan) begin
                    next_res        = ALL_ONES;
                    next_flags[F_I] = 1'b1;
                end else begin
                    next_res        = {!x_f[SGN], x_f[38:0]};
                    next_flags[F_Z] = x_zero;
                    next_flags[F_N] = !x_f[SGN] && !x_zero;
                end
            end
            OP_MAG: begin
                if (x_nan) begin
                    next_res        = ALL_ONES;
                    next_flags[F_I] = 1'b1;
                end else begin
                    next_res        = {1'b0, x_f[38:0]};
                    next_flags[F_Z] = x_zero;
                    next_flags[F_S] = first_float_source[31];
                end
            end
            OP_PASS: begin
                if (x_nan) begin
                    next_res        = ALL_ONES;
                    next_flags[F_I] = 1'b1;
                end else begin
                    next_res        = x_f;
                    next_flags[F_Z] = x_zero;
                    next_flags[F_N] = x_f[SGN] && !x_zero;
                end
            end
            default: begin
                next_res   = float_destination;
                next_flags = 7'h0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Software-written registers.

    // Operand and mode registers take byte strobes; command is write-only.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            first_float_source    <= 32'h0000_0000;
            second_float_source   <= 32'h0000_0000;
            ext_reg               <= 16'h0000;
            mode_control_register <= MODE_RST;
        end else if (acc_wr) begin
            if (paddr == FX_OFS) begin
                first_float_source <= merge(first_float_source, pwdata, pstrb);
            end
            if (paddr == FY_OFS) begin
                second_float_source <= merge(second_float_source, pwdata, pstrb);
            end
            if (paddr == EXT_OFS) begin
                ext_reg <= 16'(merge({16'h0, ext_reg}, pwdata, pstrb));
            end
            if (paddr == MODE_OFS) begin
                mode_control_register <= 2'(merge({30'h0, mode_control_register},
                                                  pwdata, pstrb));
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result and status registers.

    // The destination and all flags change together at the command edge.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            float_destination <= 40'h0;
        end else if (go) begin
            float_destination <= next_res;
        end
    end

    // Only compares move the history; other operations leave it in place.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            arithmetic_status_register <= STAT_RST;
        end else if (go) begin
            arithmetic_status_register[6:0] <= next_flags;
            if (op == OP_CMP) begin
                arithmetic_status_register[HIST_HI-1:HIST_LO] <=
                    arithmetic_status_register[HIST_HI:HIST_LO+1];
                arithmetic_status_register[HIST_HI] <=
                    !next_flags[F_Z] && !next_flags[F_N];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB answer.

    // One registered access cycle keeps every bus output on a flip-flop;
    // the price is a fixed single-cycle access phase.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped(paddr);
            prdata  <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    FX_OFS:   prdata <= first_float_source;
                    FY_OFS:   prdata <= second_float_source;
                    EXT_OFS:  prdata <= {8'h00, float_destination[7:0], ext_reg};
                    MODE_OFS: prdata <= {30'h0, mode_control_register};
                    RES_OFS:  prdata <= float_destination[39:8];
                    STAT_OFS: prdata <= arithmetic_status_register;
                    default:  prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence

    apb_ready_a: assert property (s_setup |=> s_answer)
        else $error("APB ready not a single-cycle answer.");
    abs_sign_a: assert property (go && (op == OP_ABS_ADD || op == OP_ABS_SUB)
        |=> !arithmetic_status_register[F_I] -> !float_destination[SGN])
        else $error("Absolute result carries a sign.");
    abs_flags_a: assert property (go && op == OP_ABS_SUB |=>
        arithmetic_status_register[5:4] == 2'b00 && !arithmetic_status_register[F_N]
        && (arithmetic_status_register[F_U] -> arithmetic_status_register[F_Z]))
        else $error("Absolute difference flags wrong.");
    abs_denorm_a: assert property (go && op == OP_ABS_ADD |=>
        arithmetic_status_register[F_U] -> float_destination == 40'h0)
        else $error("Denormal sum not flushed to positive zero.");
    round_32_a: assert property (go && op == OP_AVG && au.r32 && !x_nan && !y_nan
        |=> float_destination[7:0] == 8'h00)
        else $error("Short rounding left low bits.");
    nan_ones_a: assert property (go && op != OP_CMP && x_nan
        |=> float_destination == ALL_ONES && arithmetic_status_register[F_I])
        else $error("NaN input did not give all ones.");
    hist_shift_a: assert property (go && op == OP_CMP |=>
        arithmetic_status_register[30:24] == $past(arithmetic_status_register[31:25]))
        else $error("Compare history did not shift.");
    cmp_msb_a: assert property (go && op == OP_CMP |=> arithmetic_status_register[31]
        == !(arithmetic_status_register[F_Z] || arithmetic_status_register[F_N]))
        else $error("Greater bit disagrees with flags.");
    cmp_clear_a: assert property (go && op == OP_CMP |=>
        arithmetic_status_register[F_U] == 1'b0 && arithmetic_status_register[5:3] == 3'b000)
        else $error("Compare left stray flags.");
    neg_sign_a: assert property (go && op == OP_NEG && !x_nan
        |=> float_destination[SGN] != $past(x_f[SGN]))
        else $error("Negate kept the sign.");
    mag_pos_a: assert property (go && op == OP_MAG && !x_nan
        |=> !float_destination[SGN] && arithmetic_status_register[F_S] == $past(first_float_source[31]))
        else $error("Magnitude sign or sign flag wrong.");
    pass_copy_a: assert property (go && op == OP_PASS && !x_nan
        |=> float_destination == $past(x_f) && !arithmetic_status_register[F_I])
        else $error("Pass altered the operand.");
endmodule
`default_nettype wire

// ==== dv/fpabs_mst.sv ====
// APB master standing in for the register file and sequencer.
// Assumes one clock shared with the slave.
`timescale 1ns/1ps
`default_nettype none
module fpabs_mst (
    input  wire logic        ref_clk, // Clock.
    input  wire logic        pready,  // Ready.
    input  wire logic [31:0] prdata,  // Read data.
    input  wire logic        pslverr, // Error.
    output logic      [7:0]  paddr,   // Address.
    output logic             psel,    // Select.
    output logic             penable, // Access phase.
    output logic             pwrite,  // Direction.
    output logic      [31:0] pwdata   // Write data.
);
    // Error answer of the last transfer, kept for the bench to judge.
    logic err = 1'b0;
    // Idle bus from time zero.
    initial {paddr, psel, penable, pwrite, pwdata} = '0;
    // Ready, read data and error are all taken at the rising edge that closes
    // the access phase; the request is released only at that same edge.
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge ref_clk);
        {paddr, pwrite, pwdata, psel, penable} <= {a, w, d, 2'b10};
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        q   = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
endmodule
`default_nettype wire

// ==== dv/fpabs_top_bench.sv ====
// Bench for the float ALU: corner cases plus xorshift-driven negates and compares.
// Assumes the slave answers in the access cycle.
`timescale 1ns/1ps
`default_nettype none
module fpabs_top_bench import fpabs_pkg::*; ;
    localparam logic [39:0] P1 = 40'h3F80000000, M1 = 40'hBF80000000, P2 = 40'h4000000000;
    localparam logic [39:0] P3 = 40'h4040000000, M3 = 40'hC040000000, NAN = 40'h7FC0000000;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [3:0] pstrb = 4'hF;
    logic [7:0] paddr, hist = 8'h00;
    logic [31:0] pwdata, prdata, q, s = 32'h7D4F8BF3;
    logic [39:0] x;
    int failures = 0, total_checks = 0, cycles = 0;
    always #12.5 ref_clk = ~ref_clk;
    fpabs_mst u_mst (.*);
    fpabs_top u_dut (.*);
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] next_rand(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction
    task automatic check(input string n, input logic [39:0] e, input logic [39:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // A compare defines flags and history only, so its result word is not judged.
    task automatic run(input logic [39:0] a, b, input logic [2:0] op, input logic [39:0] e,
        input logic [6:0] f);
        logic [31:0] r;
        u_mst.xfer(FX_OFS, 1'b1, a[39:8], q);
        u_mst.xfer(FY_OFS, 1'b1, b[39:8], q);
        u_mst.xfer(EXT_OFS, 1'b1, {16'h0000, b[7:0], a[7:0]}, q);
        u_mst.xfer(CMD_OFS, 1'b1, {29'h0, op}, q);
        if (op == OP_CMP)
            hist = {~f[F_Z] & ~f[F_N], hist[7:1]};
        u_mst.xfer(RES_OFS, 1'b0, 32'h0, r);
        u_mst.xfer(EXT_OFS, 1'b0, 32'h0, q);
        if (op != OP_CMP)
            check("result", e, {r, q[23:16]});
        u_mst.xfer(STAT_OFS, 1'b0, 32'h0, q);
        check("status", {8'h00, hist, 17'h0, f}, {8'h00, q});
        check("slverr", 40'h0, {39'h0, u_mst.err});
    endtask
    ////////////////////////////////////////////////////////////////
    // Hang guard; the run needs about 1600 cycles.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            stop_test();
        end
    end
    // Each mode: fractions above half below the 32-bit boundary; the two 40-bit modes then overflow.
    initial begin
        repeat (16) @(posedge ref_clk);
        nrst <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            u_mst.xfer(MODE_OFS, 1'b1, 32'(m), q);
            run(40'h3F800000C0, '0, OP_ABS_ADD, m == 2 ? 40'h3F80000100 :
                m == 3 ? P1 : 40'h3F800000C0, 7'h00);
            run(P1, 40'h3F800001C0, OP_AVG, m == 2 ? 40'h3F80000100 :
                m == 3 ? P1 : 40'h3F800000E0, 7'h00);
            if (m < 2)
                run(LARGEST_NORMAL_VALUE, LARGEST_NORMAL_VALUE, OP_ABS_ADD, m[0] ? LARGEST_NORMAL_VALUE : POS_INF, 7'h08);
        end
        u_mst.xfer(MODE_OFS, 1'b1, 32'h0, q);
        run(P1, M3, OP_ABS_ADD, P2, 7'h00);
        run(P1, P3, OP_ABS_SUB, P2, 7'h00);
        run(M3, M1, OP_AVG, 40'hC000000000, 7'h04);
        run(40'h0080000100, 40'h0080000000, OP_ABS_SUB, '0, 7'h03);
        run(40'h8080000000, '0, OP_AVG, 40'h8000000000, 7'h03);
        run(POS_INF, 40'hFF80000000, OP_ABS_ADD, ALL_ONES, 7'h40);
        run(POS_INF, POS_INF, OP_ABS_SUB, ALL_ONES, 7'h40);
        run(NAN, '0, OP_PASS, ALL_ONES, 7'h40);
        run(P3, P1, OP_CMP, '0, 7'h00);
        run(P1, P1, OP_CMP, '0, 7'h01);
        run(P1, P3, OP_CMP, '0, 7'h04);
        run(NAN, P1, OP_CMP, '0, 7'h40);
        run(40'h0000000100, '0, OP_NEG, 40'h8000000000, 7'h01);
        run(M3, '0, OP_MAG, P3, 7'h20);
        run(40'h8000000100, '0, OP_MAG, '0, 7'h21);
        run(M1, '0, OP_PASS, M1, 7'h04);
        // Random normal operands; compares against the negation fill the history.
        for (int i = 0; i < 24; i++) begin
            s = next_rand(s);
            x = {s[31], 2'b01, s[28:0], s[7:0]};
            run(x, '0, OP_NEG, {~x[39], x[38:0]}, {4'h0, ~x[39], 2'b00});
            run(x, {~x[39], x[38:0]}, OP_CMP, '0, {4'h0, x[39], 2'b00});
        end
        // An unused command code leaves status alone; an unmapped read errors.
        u_mst.xfer(CMD_OFS, 1'b1, 32'h0000_0007, q);
        u_mst.xfer(STAT_OFS, 1'b0, 32'h0, q);
        check("ignored", {8'h00, hist, 17'h0, 4'h0, x[39], 2'b00}, {8'h00, q});
        u_mst.xfer(8'h1C, 1'b0, 32'h0, q);
        check("slverr", 40'h1, {39'h0, u_mst.err});
        check("unmapped", 40'h0, {8'h00, q});
        stop_test();
    end
endmodule
`default_nettype wire
